// [rtl/ubir_defines.vh]
/*
 * Register map, field positions and reset values of the USB device
 * interrupt and pointer register slice.
 * Assumes an 8-bit I/O bus with byte offsets relative to the block base.
 */
//
// Contract
// [RQ1] Write pointer 5 bits; writing flushes both pointers
// [RQ2] Read pointer 5 bits; writing also flushes
// [RQ3] 16-bit table base, bit 0 reads zero
// [RQ4] Unimplemented table base bits read zero
// [RQ5] Bit 7 enables frame start interrupt
// [RQ6] Bit 6 enables suspend, resume, reset interrupts
// [RQ7] Bit 5 enables checksum, underflow, overflow interrupts
// [RQ8] Bit 4 enables stall handshake interrupt
// [RQ9] Two-bit level; zero suppresses all interrupts
// [RQ10] Second register bit 1 enables transfer done
// [RQ11] Second register bit 0 enables setup done
// [RQ12] Flags at two addresses: clear, set
// [RQ13] Frame start packet sets flag bit 7
// [RQ14] Idle bus 3 ms sets flag bit 6
// [RQ15] Non-idle while suspended sets flag bit 5
// [RQ16] Resume detection works without system clock; latch catches one wake, cleared only by pin reset
// [RQ17] Bus reset sets flag bit 4
// [RQ18] Isochronous checksum error sets flag bit 3
// [RQ19] IN without data sets flag bit 2
// [RQ20] OUT refused sets flag bit 1
// [RQ21] STALL handshake sets flag bit 0
// [RQ22] All registers reset zero, reserved read zero
// [RQ23] Queue enable records table address per completion
// [RQ24] Request at level while enabled flag pending
// [RQ25] Hardware event wins over clear
`ifndef UBIR_DEFINES_VH
`define UBIR_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UBIR_OFS_FIFO_WR 8'h04
`define UBIR_OFS_FIFO_RD 8'h05
`define UBIR_OFS_TBL_LO 8'h06
`define UBIR_OFS_TBL_HI 8'h07
`define UBIR_OFS_FLAG_CLR 8'h0A
`define UBIR_OFS_FLAG_SET 8'h0B

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UBIR_BIT_SOF 7
`define UBIR_BIT_BUSEV 6
`define UBIR_BIT_BUSERR 5
`define UBIR_BIT_STALL 4
`define UBIR_BIT_XFER 1
`define UBIR_BIT_SETUP 0
`define UBIR_FLG_SOF 7
`define UBIR_FLG_IDLE 6
`define UBIR_FLG_WAKE 5
`define UBIR_FLG_RST 4
`define UBIR_FLG_CRC 3
`define UBIR_FLG_UNF 2
`define UBIR_FLG_OVF 1
`define UBIR_FLG_STL 0

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define UBIR_RST_BYTE 8'h00
`define UBIR_RST_PTR 5'h00
`define UBIR_CTRLA_MASK 8'hF3
`define UBIR_CTRLB_MASK 8'h03
`define UBIR_IDLE_TIME_US 3000
`define UBIR_CLK_MHZ 10
`define UBIR_IDLE_CYCLES (`UBIR_IDLE_TIME_US * `UBIR_CLK_MHZ)

`endif

// [rtl/ubir_queue_mem.v]
/*
 * Small memory for the transaction completion queue.
 * Assumes one write port and one read port on the same clock;
 * read data leave through a register.
 */
`timescale 1ns/1ps
module ubir_queue_mem #(
	parameter AW = 5,
	parameter DW = 16
) (
	// Clock
	input wire clk,
	// Write side
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	// Read side
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data_ff
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	// Write entry, registered read
	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_ff <= mem[rd_addr];
	end

endmodule

// [rtl/ubir_regs.v]
/*
 * Interrupt flag, interrupt control, completion queue pointer and
 * endpoint table base registers of a USB device controller.
 * Assumes an 8-bit I/O bus with one-cycle read and write strobes and
 * event pulses from the USB engine synchronous to clk.
 */
`timescale 1ns/1ps
`include "ubir_defines.vh"
module ubir_regs #(
	parameter TBL_BITS = 12,
	parameter IDLE_CYCLES = `UBIR_IDLE_CYCLES
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// I/O bus
	input wire [7:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	output reg [7:0] io_rdata_ff,
	// Engine events
	input wire ev_frame_start,
	input wire ev_bus_reset,
	input wire ev_iso_crc_err,
	input wire ev_in_no_data,
	input wire ev_out_refused,
	input wire ev_stall,
	input wire ev_xfer_done,
	input wire ev_setup_done,
	input wire [15:0] ev_ep_table_addr,
	input wire bus_idle,
	input wire bus_wake_async,
	input wire completion_queue_enable,
	// Flag register B state
	input wire xfer_flag,
	input wire setup_flag,
	// Outputs
	output reg [1:0] irq_level_ff,
	output reg irq_req_ff,
	output reg suspended_ff,
	output reg [15:0] queue_head_ff
);

	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	reg rst_s1_ff;
	reg rst_s2_ff;
	wire srst_n = rst_s2_ff;

	// Two flops release reset
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [4:0] completion_fifo_wr_ptr_ff;
	reg [4:0] completion_fifo_rd_ptr_ff;
	reg [15:0] endpoint_table_base_ff;
	reg [7:0] irq_control_first_ff;
	reg [7:0] irq_control_second_ff;
	reg [7:0] event_flags_ff;
	reg [31:0] idle_cnt_ff;
	reg wake_seen_ff;
	reg wake_s1_ff;
	reg wake_s2_ff;
	reg [7:0] nxt_flags;
	reg [7:0] hw_set;
	reg [7:0] nxt_rdata;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	reg wr_wp;
	reg wr_rp;
	reg wr_lo;
	reg wr_hi;
	reg wr_clr;
	reg wr_set;
	wire flush;

	// One write strobe per offset
	always @* begin
		wr_wp = 1'b0;
		wr_rp = 1'b0;
		wr_lo = 1'b0;
		wr_hi = 1'b0;
		wr_clr = 1'b0;
		wr_set = 1'b0;
		if (io_wr) begin
			case (io_addr)
				`UBIR_OFS_FIFO_WR: wr_wp = 1'b1;
				`UBIR_OFS_FIFO_RD: wr_rp = 1'b1;
				`UBIR_OFS_TBL_LO: wr_lo = 1'b1;
				`UBIR_OFS_TBL_HI: wr_hi = 1'b1;
				`UBIR_OFS_FLAG_CLR: wr_clr = 1'b1;
				`UBIR_OFS_FLAG_SET: wr_set = 1'b1;
				default: wr_wp = 1'b0;
			endcase
		end
	end

	// Any pointer write flushes the queue
	assign flush = wr_wp | wr_rp; // RQ1 RQ2

	// ----------------------------------------
	// Table base mask
	// ----------------------------------------
	// Bit 0 and bits from TBL_BITS up are absent, so they read zero
	wire [15:0] tbl_mask;
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_mask
			assign tbl_mask[gi] = (gi != 0) && (gi < TBL_BITS); // RQ3 RQ4
		end
	endgenerate

	// ----------------------------------------
	// Completion queue
	// ----------------------------------------
	wire push = completion_queue_enable && ev_xfer_done; // RQ23
	wire [15:0] q_rd_data;

	ubir_queue_mem #(
		.AW(5),
		.DW(16)
	) u_mem (
		.clk(clk),
		.wr_en(push),
		.wr_addr(completion_fifo_wr_ptr_ff),
		.wr_data(ev_ep_table_addr),
		.rd_addr(completion_fifo_rd_ptr_ff),
		.rd_data_ff(q_rd_data)
	);

	// Pointer update, flush on any pointer write
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			completion_fifo_wr_ptr_ff <= `UBIR_RST_PTR;
			completion_fifo_rd_ptr_ff <= `UBIR_RST_PTR;
			queue_head_ff <= 16'h0000;
		end else if (!srst_n) begin
			completion_fifo_wr_ptr_ff <= `UBIR_RST_PTR;
			completion_fifo_rd_ptr_ff <= `UBIR_RST_PTR;
			queue_head_ff <= 16'h0000;
		end else begin
			queue_head_ff <= q_rd_data;
			if (flush || !completion_queue_enable) begin
				completion_fifo_wr_ptr_ff <= `UBIR_RST_PTR; // RQ1
				completion_fifo_rd_ptr_ff <= `UBIR_RST_PTR; // RQ2
			end else if (push) begin
				completion_fifo_wr_ptr_ff <= completion_fifo_wr_ptr_ff + 5'h01; // RQ23
			end
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			endpoint_table_base_ff <= 16'h0000;
			irq_control_first_ff <= `UBIR_RST_BYTE;
			irq_control_second_ff <= `UBIR_RST_BYTE;
		end else if (!srst_n) begin
			endpoint_table_base_ff <= 16'h0000; // RQ22
			irq_control_first_ff <= `UBIR_RST_BYTE;
			irq_control_second_ff <= `UBIR_RST_BYTE;
		end else begin
			// Table base and control share offsets 6 and 7
			if (wr_lo) begin
				endpoint_table_base_ff[7:0] <= io_wdata & tbl_mask[7:0]; // RQ3
				irq_control_first_ff <= io_wdata & `UBIR_CTRLA_MASK;
			end
			if (wr_hi) begin
				endpoint_table_base_ff[15:8] <= io_wdata & tbl_mask[15:8]; // RQ4
				irq_control_second_ff <= io_wdata & `UBIR_CTRLB_MASK;
			end
		end
	end

	// ----------------------------------------
	// Suspend timer and resume capture
	// ----------------------------------------
	// Resume latch runs on the bus line itself, so no clock is needed.
	// It is only cleared by the pin reset: a second resume while the
	// latch is still set gives no new edge to the synchroniser.
	// Users must reset the block after each wake to rearm it.
	// Resume latch
	always @(posedge bus_wake_async or negedge rst_n) begin
		if (!rst_n) begin
			wake_seen_ff <= 1'b0;
		end else begin
			wake_seen_ff <= 1'b1; // RQ16
		end
	end

	// Synchronise the latch; no acknowledge, only pin reset clears it
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_s1_ff <= 1'b0;
			wake_s2_ff <= 1'b0;
		end else begin
			wake_s1_ff <= wake_seen_ff;
			wake_s2_ff <= wake_s1_ff;
		end
	end

	reg wake_prev_ff;
	wire wake_rise = wake_s2_ff && !wake_prev_ff;

	// Idle time reached; counter saturates, so this fires once
	wire idle_done = bus_idle && (idle_cnt_ff == IDLE_CYCLES - 1);

	// Idle counter and suspend state
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt_ff <= 32'h0000_0000;
			suspended_ff <= 1'b0;
			wake_prev_ff <= 1'b0;
		end else if (!srst_n) begin
			idle_cnt_ff <= 32'h0000_0000;
			suspended_ff <= 1'b0;
			wake_prev_ff <= 1'b0;
		end else begin
			wake_prev_ff <= wake_s2_ff;
			if (!bus_idle) begin
				idle_cnt_ff <= 32'h0000_0000;
			end else if (idle_cnt_ff < IDLE_CYCLES) begin
				idle_cnt_ff <= idle_cnt_ff + 32'h0000_0001;
			end
			if (suspended_ff && (!bus_idle || wake_rise)) begin
				suspended_ff <= 1'b0;
			end else if (idle_done) begin
				suspended_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Event flags
	// ----------------------------------------
	always @* begin
		hw_set = 8'h00;
		hw_set[`UBIR_FLG_SOF] = ev_frame_start; // RQ13
		hw_set[`UBIR_FLG_IDLE] = idle_done; // RQ14
		hw_set[`UBIR_FLG_WAKE] = suspended_ff && (!bus_idle || wake_rise); // RQ15
		hw_set[`UBIR_FLG_RST] = ev_bus_reset; // RQ17
		hw_set[`UBIR_FLG_CRC] = ev_iso_crc_err; // RQ18
		hw_set[`UBIR_FLG_UNF] = ev_in_no_data; // RQ19
		hw_set[`UBIR_FLG_OVF] = ev_out_refused; // RQ20
		hw_set[`UBIR_FLG_STL] = ev_stall; // RQ21
		nxt_flags = event_flags_ff;
		if (wr_clr) begin
			nxt_flags = nxt_flags & ~io_wdata; // RQ12
		end
		if (wr_set) begin
			nxt_flags = nxt_flags | io_wdata; // RQ12
		end
		nxt_flags = nxt_flags | hw_set; // RQ25
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			event_flags_ff <= `UBIR_RST_BYTE;
		end else if (!srst_n) begin
			event_flags_ff <= `UBIR_RST_BYTE; // RQ22
		end else begin
			event_flags_ff <= nxt_flags;
		end
	end

	// ----------------------------------------
	// Interrupt request
	// ----------------------------------------
	// Sources are grouped per enable bit; one enable may cover
	// several flags, so software must read the flags to tell them
	// apart. Level is registered with the request so both move
	// together and a level of zero never shows a live request.
	wire [7:0] fl = event_flags_ff;
	wire [7:0] ca = irq_control_first_ff;
	wire [7:0] cb = irq_control_second_ff;
	wire src_sof = ca[`UBIR_BIT_SOF] & fl[`UBIR_FLG_SOF]; // RQ5
	wire src_bev = ca[`UBIR_BIT_BUSEV] &
		(fl[`UBIR_FLG_IDLE] | fl[`UBIR_FLG_WAKE] | fl[`UBIR_FLG_RST]); // RQ6
	wire src_err = ca[`UBIR_BIT_BUSERR] &
		(fl[`UBIR_FLG_CRC] | fl[`UBIR_FLG_UNF] | fl[`UBIR_FLG_OVF]); // RQ7
	wire src_stl = ca[`UBIR_BIT_STALL] & fl[`UBIR_FLG_STL]; // RQ8
	wire src_xfr = cb[`UBIR_BIT_XFER] & xfer_flag; // RQ10
	wire src_set = cb[`UBIR_BIT_SETUP] & setup_flag; // RQ11
	wire any_src = src_sof | src_bev | src_err | src_stl | src_xfr | src_set;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_req_ff <= 1'b0;
			irq_level_ff <= 2'b00;
		end else if (!srst_n) begin
			irq_req_ff <= 1'b0;
			irq_level_ff <= 2'b00;
		end else begin
			irq_level_ff <= ca[1:0]; // RQ9
			irq_req_ff <= any_src && (ca[1:0] != 2'b00); // RQ9 RQ24
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always @* begin
		case (io_addr)
			`UBIR_OFS_FIFO_WR: nxt_rdata = {3'b000, completion_fifo_wr_ptr_ff};
			`UBIR_OFS_FIFO_RD: nxt_rdata = {3'b000, completion_fifo_rd_ptr_ff};
			`UBIR_OFS_TBL_LO: nxt_rdata = endpoint_table_base_ff[7:0] & tbl_mask[7:0]; // RQ3
			`UBIR_OFS_TBL_HI: nxt_rdata = endpoint_table_base_ff[15:8] & tbl_mask[15:8]; // RQ4
			`UBIR_OFS_FLAG_CLR: nxt_rdata = event_flags_ff; // RQ12
			`UBIR_OFS_FLAG_SET: nxt_rdata = event_flags_ff; // RQ12
			default: nxt_rdata = 8'h00;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata_ff <= 8'h00;
		end else if (!srst_n) begin
			io_rdata_ff <= 8'h00;
		end else if (io_rd) begin
			io_rdata_ff <= nxt_rdata;
		end
	end

endmodule

// [testbench/ubir_regs_monitor.sv]
/* Checker for the USB interrupt and pointer registers.
   Assumes a bind to ubir_regs, one clock domain. */
`timescale 1ns/1ps
module ubir_regs_monitor #(
	parameter TBL_BITS = 12,
	parameter IDLE_CYCLES = 20
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// I/O bus
	input wire [7:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	input wire [7:0] io_rdata_ff,
	// Events and outputs
	input wire ev_frame_start,
	input wire bus_idle,
	input wire xfer_flag,
	input wire [1:0] irq_level_ff,
	input wire irq_req_ff,
	input wire suspended_ff
);
	logic [7:0] ctrl_a_ff;
	logic [1:0] ctrl_b_ff;
	logic [31:0] idle_cnt_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----
	// Shadow of control bytes and idle time
	// ----
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_a_ff <= 8'h00;
			ctrl_b_ff <= 2'h0;
			idle_cnt_ff <= 32'h0000_0000;
		end else begin
			if (io_wr && io_addr == 8'h06) ctrl_a_ff <= io_wdata;
			if (io_wr && io_addr == 8'h07) ctrl_b_ff <= io_wdata[1:0];
			idle_cnt_ff <= bus_idle ? idle_cnt_ff + 1 : 32'h0000_0000;
		end
	end
	// Frame start seen with its enable and a level
	sequence sof_hit;
		ev_frame_start && ctrl_a_ff[7] && ctrl_a_ff[1:0] != 2'h0 && !io_wr ##1 !io_wr;
	endsequence
	// ----
	// Assertions
	// ----
	chk_sof_irq_up: assert property (sof_hit |=> irq_req_ff)
		else $error("frame start did not raise request");
	chk_level_zero_quiet: assert property (irq_level_ff == 2'h0 |-> !irq_req_ff)
		else $error("request with level zero");
	chk_level_copy: assert property (io_wr && io_addr == 8'h06 |-> ##2 irq_level_ff == $past(io_wdata[1:0], 2))
		else $error("level field not loaded");
	chk_xfer_irq_up: assert property ((xfer_flag && ctrl_b_ff[1] && ctrl_a_ff[1:0] != 2'h0)[*2] |-> irq_req_ff)
		else $error("transfer done did not raise request");
	chk_ptr_reserved: assert property (io_rd && (io_addr == 8'h04 || io_addr == 8'h05) |=> io_rdata_ff[7:5] == 3'h0)
		else $error("pointer reserved bits not zero");
	chk_tbl_align: assert property (io_rd && io_addr == 8'h06 |=> !io_rdata_ff[0])
		else $error("table base bit 0 not zero");
	chk_tbl_unimpl: assert property (io_rd && io_addr == 8'h07 |=> (io_rdata_ff >> (TBL_BITS - 8)) == 8'h00)
		else $error("unimplemented base bits not zero");
	chk_unmapped_zero: assert property (io_rd && io_addr == 8'h00 |=> io_rdata_ff == 8'h00)
		else $error("unmapped read not zero");
	chk_idle_early: assert property ($rose(suspended_ff) && bus_idle |-> idle_cnt_ff >= IDLE_CYCLES - 2)
		else $error("suspend before idle time");
	chk_idle_late: assert property (idle_cnt_ff == IDLE_CYCLES + 3 |-> suspended_ff)
		else $error("suspend missing after idle time");
endmodule
bind ubir_regs ubir_regs_monitor #(.TBL_BITS(TBL_BITS), .IDLE_CYCLES(IDLE_CYCLES)) ubir_regs_monitor_i (
	.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
	.io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .ev_frame_start(ev_frame_start),
	.bus_idle(bus_idle), .xfer_flag(xfer_flag), .irq_level_ff(irq_level_ff),
	.irq_req_ff(irq_req_ff), .suspended_ff(suspended_ff));

// [testbench/ubir_host_model.sv]
/* Model of the USB engine and host traffic: one-cycle event pulses.
   Assumes a caller that invokes send once at a time. */
`timescale 1ns/1ps
module ubir_host_model (
	// Clock
	input wire clk,
	// Event pulses
	output logic [7:0] ev_ff,
	output logic [15:0] ev_ep_table_addr
);
	initial ev_ff = 8'h00;
	initial ev_ep_table_addr = 16'hFFFF;
	// Pulse one event; address is spoiled once the pulse ends
	task automatic send(input int k, input logic [15:0] a);
		@(posedge clk);
		ev_ff <= 8'h01 << k;
		ev_ep_table_addr <= a;
		@(posedge clk);
		ev_ff <= 8'h00;
		ev_ep_table_addr <= ~a;
	endtask
endmodule

// [testbench/ubir_regs_tb.sv]
/* Self-checking bench for the USB interrupt and pointer registers.
   Assumes the host model drives the engine events. */
`timescale 1ns/1ps
module ubir_regs_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] io_addr = 8'h00;
	logic io_wr = 1'b0;
	logic io_rd = 1'b0;
	logic [7:0] io_wdata = 8'h00;
	logic bus_idle = 1'b0;
	logic bus_wake_async = 1'b0;
	logic cq_en = 1'b0;
	logic xfer_flag = 1'b0;
	logic setup_flag = 1'b0;
	wire [7:0] io_rdata_ff;
	wire [7:0] ev;
	wire [15:0] ev_addr;
	wire [1:0] irq_level_ff;
	wire irq_req_ff;
	wire suspended_ff;
	wire [15:0] queue_head_ff;
	int err_count = 0;
	int total_checks = 0;
	int i;
	logic [7:0] flg [6] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
	logic [7:0] ena [6] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h20, 8'h10};
	logic [7:0] offs [7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0A, 8'h0B, 8'h00};
	always #50 clk = ~clk;
	ubir_host_model ubir_host_model_i (.clk(clk), .ev_ff(ev), .ev_ep_table_addr(ev_addr));
	ubir_regs #(.IDLE_CYCLES(20)) ubir_regs_i (
		.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .ev_frame_start(ev[0]),
		.ev_bus_reset(ev[1]), .ev_iso_crc_err(ev[2]), .ev_in_no_data(ev[3]),
		.ev_out_refused(ev[4]), .ev_stall(ev[5]), .ev_xfer_done(ev[6]),
		.ev_setup_done(ev[7]), .ev_ep_table_addr(ev_addr), .bus_idle(bus_idle),
		.bus_wake_async(bus_wake_async), .completion_queue_enable(cq_en),
		.xfer_flag(xfer_flag), .setup_flag(setup_flag), .irq_level_ff(irq_level_ff),
		.irq_req_ff(irq_req_ff), .suspended_ff(suspended_ff), .queue_head_ff(queue_head_ff));
	// ----
	// Bus and compare tasks
	// ----
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge clk);
		io_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clk);
		io_rd <= 1'b0;
		#1 chk_val({8'h00, io_rdata_ff}, {8'h00, e});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task give_verdict;
		if (err_count == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (50000) @(posedge clk);
		err_count++;
		give_verdict;
	end
	// ----
	// Main sequence
	// ----
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (i = 0; i < 7; i++) rd(offs[i], 8'h00);
		for (i = 0; i < 6; i++) begin
			wr(8'h0A, 8'hFF);
			ubir_host_model_i.send(i, 16'h0000);
			rd(8'h0B, flg[i]);
			wr(8'h06, ena[i] | 8'h02);
			tick(2);
			chk_bit(irq_req_ff, 1'b1);
			chk_val({14'h0000, irq_level_ff}, 16'h0002);
			wr(8'h06, ena[i]);
			tick(2);
			chk_bit(irq_req_ff, 1'b0);
			wr(8'h06, (8'hF0 & ~ena[i]) | 8'h03);
			tick(2);
			chk_bit(irq_req_ff, 1'b0);
		end
		wr(8'h0B, 8'hFF);
		rd(8'h0A, 8'hFF);
		wr(8'h0A, 8'h0F);
		rd(8'h0B, 8'hF0);
		fork
			wr(8'h0A, 8'hFF);
			ubir_host_model_i.send(0, 16'h0000);
		join
		rd(8'h0A, 8'h80);
		wr(8'h0A, 8'hFF);
		wr(8'h06, 8'hFF);
		wr(8'h07, 8'hFF);
		rd(8'h06, 8'hFE);
		rd(8'h07, 8'h0F);
		ubir_host_model_i.send(0, 16'h0000);
		tick(1);
		chk_bit(irq_req_ff, 1'b1);
		wr(8'h0A, 8'hFF);
		xfer_flag <= 1'b1;
		tick(3);
		chk_bit(irq_req_ff, 1'b1);
		wr(8'h07, 8'h01);
		tick(2);
		chk_bit(irq_req_ff, 1'b0);
		setup_flag <= 1'b1;
		tick(3);
		chk_bit(irq_req_ff, 1'b1);
		wr(8'h07, 8'h02);
		xfer_flag <= 1'b0;
		tick(3);
		chk_bit(irq_req_ff, 1'b0);
		cq_en <= 1'b1;
		ubir_host_model_i.send(6, 16'h0120);
		ubir_host_model_i.send(6, 16'h0130);
		ubir_host_model_i.send(6, 16'h0140);
		rd(8'h04, 8'h03);
		rd(8'h05, 8'h00);
		chk_val(queue_head_ff, 16'h0120);
		wr(8'h05, 8'h00);
		rd(8'h04, 8'h00);
		ubir_host_model_i.send(6, 16'h0150);
		wr(8'h04, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'h05, 8'h00);
		wr(8'h0A, 8'hFF);
		bus_idle <= 1'b1;
		for (i = 0; i < 100 && suspended_ff !== 1'b1; i++) tick(1);
		chk_bit(suspended_ff, 1'b1);
		if (i == 100) give_verdict;
		rd(8'h0A, 8'h40);
		bus_wake_async <= 1'b1;
		tick(1);
		bus_wake_async <= 1'b0;
		tick(4);
		chk_bit(suspended_ff, 1'b0);
		rd(8'h0A, 8'h60);
		bus_idle <= 1'b0;
		give_verdict;
	end
endmodule
